// ===== hdl/ast_corr.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// offset and gain correction with saturation
module ast_corr (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // coefficients for the sample's channel
    input wire logic [15:0] gain_i,
    input wire logic [15:0] offs_i,
    input wire logic cur_i,
    // raw sample in, corrected sample out
    ast_smp_if.dst raw,
    ast_smp_if.src cor
);
    logic [31:0] prod;
    logic signed [18:0] sum;
    logic [15:0] res_d;
    logic [15:0] res_q;
    logic vld_q;
    logic [2:0] ch_q;

    // scale by gain, add signed offset, clip at both ends
    always_comb begin
        prod = raw.data * gain_i;
        sum = $signed({2'b00, prod[31:ast_pkg::GAIN_SHIFT]}) + $signed({{3{offs_i[15]}}, offs_i});
        if (sum < 0) begin
            res_d = 16'h0000;
        end else if (sum > $signed({3'b000, ast_pkg::SMP_MAX})) begin
            res_d = ast_pkg::SMP_MAX;
        end else begin
            res_d = sum[15:0];
        end
        if (cur_i) begin
            res_d[0] = 1'b0;
        end
    end

    // result register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vld_q <= 1'b0;
            ch_q <= 3'h0;
            res_q <= 16'h0000;
        end else begin
            vld_q <= raw.valid;
            ch_q <= raw.chan;
            res_q <= res_d;
        end
    end

    assign cor.valid = vld_q;
    assign cor.chan = ch_q;
    assign cor.data = res_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_corr_latency: assert property (raw.valid |=> cor.valid && cor.chan == $past(raw.chan))
        else $error("corrected sample not one cycle after raw");
    a_cur_lsb: assert property (raw.valid && cur_i |=> cor.data[0] == 1'b0)
        else $error("current sample keeps its lowest bit");
endmodule : ast_corr
`default_nettype wire

// ===== hdl/ast_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// simple dual port sample store, registered read
module ast_mem #(
    parameter int W = ast_pkg::ENT_W,
    parameter int DEPTH = ast_pkg::FIFO_DEPTH,
    parameter int AW = ast_pkg::FIFO_AW
) (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    // read port
    input wire logic [AW-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem [DEPTH];

    // write and registered read
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : ast_mem
`default_nettype wire

// ===== hdl/ast_scan_timing.sv
// Notes on behaviour
// - the converter tick comes from a 40 MHz time base divided by the software divisor.
// - the divisor runs from 200 up to two to the thirty-two minus one.
// - divisors below 200 act as 200, so ticks never exceed 200 kS/s.
// - each tick converts one enabled channel, sharing the rate among them.
// - acquisition starts only on a software trigger write, never from hardware.
// - eight channels, each with its own enable; disabled ones are never converted.
// - results are 16 bits, current-mode channels keep 15 bits by clearing the lowest.
// - buffered samples of all channels go interleaved into one 4096 entry fifo.
// - a per-channel signed offset is added, a larger value raising the code.
// - a per-channel gain scales the code, a larger value raising it.
// - corrected results clip at 0 and 65535 instead of wrapping.
// - channels are scanned upward, skipping disabled ones, then wrap to the lowest.
// - buffered mode writes results to the fifo, single mode sends them to the host.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module ast_scan_timing #(
    parameter int FIFO_DEPTH = ast_pkg::FIFO_DEPTH,
    parameter int FIFO_AW = ast_pkg::FIFO_AW
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // converter
    input wire logic conv_done_i,
    input wire logic [15:0] conv_data_i,
    output logic conv_start_o,
    output logic [2:0] conv_chan_o,
    // immediate result to host link
    output logic direct_valid_o,
    output logic [2:0] direct_chan_o,
    output logic [15:0] direct_data_o
);
    localparam int LW = FIFO_AW + 1;

    // ============================================================
    // elaboration check
    if (FIFO_DEPTH != (1 << FIFO_AW) || FIFO_AW < 2) begin : g_chk
        $error("fifo depth must be a power of two matching its address width");
    end

    // ============================================================
    // helpers
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                o[8*b +: 8] = n[8*b +: 8];
            end
        end
        return o;
    endfunction : wmerge

    // first enabled channel above cur, else the lowest enabled
    function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] en);
        logic [2:0] lo;
        logic [2:0] up;
        logic fl;
        logic fu;
        lo = 3'h0;
        up = 3'h0;
        fl = 1'b0;
        fu = 1'b0;
        for (int c = 7; c >= 0; c--) begin
            if (en[c]) begin
                lo = 3'(c);
                fl = 1'b1;
                if (3'(c) > cur) begin
                    up = 3'(c);
                    fu = 1'b1;
                end
            end
        end
        return fu ? up : lo;
    endfunction : next_chan

    function automatic logic [3:0] count_en(input logic [7:0] en);
        logic [3:0] n;
        n = 4'h0;
        for (int c = 0; c < 8; c++) begin
            n = n + {3'b000, en[c]};
        end
        return n;
    endfunction : count_en

    // ============================================================
    // declarations
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic run_set, run_clr, single_q, single_d;
    logic [31:0] div_q, div_d, div_eff;
    logic [7:0] chen_q, chen_d, cur_q, cur_d;
    logic [15:0] offs_q [8];
    logic [15:0] offs_d [8];
    logic [15:0] gain_q [8];
    logic [15:0] gain_d [8];
    logic ovf_q, ovf_d, fresh_q, fresh_d;
    logic req, wr, rd, pop, ovf_set;
    logic [8:0] tb_acc_q, tb_acc_d, tb_sum;
    logic tb_en, tick_q, tick_d;
    logic [31:0] div_cnt_q, div_cnt_d;
    ast_pkg::ast_scan_t state_q, state_d;
    logic [2:0] chan_q, chan_d, nxt;
    logic start_q, start_d;
    logic done_s1, done_s2, done_s3;
    logic [15:0] data_s1, data_s2;
    logic [LW-1:0] wr_q, wr_d, rd_q, rd_d, wr_vis_q, level;
    logic full, empty, push_req, push;
    logic [ast_pkg::ENT_W-1:0] rdata;
    logic dv_q, dv_d;
    logic [2:0] dch_q, dch_d;
    logic [15:0] dda_q, dda_d;

    ast_smp_if raw_if ();
    ast_smp_if cor_if ();

    // ============================================================
    // register bus
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign pop = rd && wb_adr_i == ast_pkg::ADR_FIFO && wr_vis_q != rd_q;
    assign run_set = wr && wb_adr_i == ast_pkg::ADR_CTRL && wb_sel_i[0]
                     && wb_dat_i[ast_pkg::CTRL_TRIG];
    assign run_clr = wr && wb_adr_i == ast_pkg::ADR_CTRL && wb_sel_i[0]
                     && wb_dat_i[ast_pkg::CTRL_STOP];

    // register writes, read mux, sticky flags
    always_comb begin
        logic [31:0] m;
        m = 32'h0000_0000;
        ack_d = req;
        dat_d = dat_q;
        single_d = single_q;
        div_d = div_q;
        chen_d = chen_q;
        cur_d = cur_q;
        offs_d = offs_q;
        gain_d = gain_q;
        ovf_d = ovf_q;
        fresh_d = fresh_q;
        if (wr) begin
            if (wb_adr_i == ast_pkg::ADR_CTRL && wb_sel_i[0]) begin
                single_d = wb_dat_i[ast_pkg::CTRL_SINGLE];
            end
            if (wb_adr_i == ast_pkg::ADR_DIV) begin
                div_d = wmerge(div_q, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == ast_pkg::ADR_CHEN) begin
                m = wmerge({16'h0000, cur_q, chen_q}, wb_dat_i, wb_sel_i);
                chen_d = m[7:0];
                cur_d = m[ast_pkg::CHEN_CUR_LSB +: 8];
            end
            if (wb_adr_i == ast_pkg::ADR_STAT && wb_sel_i[0] && wb_dat_i[ast_pkg::STAT_OVF]) begin
                ovf_d = 1'b0;
            end
            for (int c = 0; c < 8; c++) begin
                if (wb_adr_i == ast_pkg::ADR_OFFS + 8'(4 * c)) begin
                    m = wmerge({16'h0000, offs_q[c]}, wb_dat_i, wb_sel_i);
                    offs_d[c] = m[15:0];
                end
                if (wb_adr_i == ast_pkg::ADR_GAIN + 8'(4 * c)) begin
                    m = wmerge({16'h0000, gain_q[c]}, wb_dat_i, wb_sel_i);
                    gain_d[c] = m[15:0];
                end
            end
        end
        if (rd) begin
            dat_d = 32'h0000_0000;
            if (wb_adr_i == ast_pkg::ADR_CTRL) begin
                dat_d[ast_pkg::CTRL_SINGLE] = single_q;
                dat_d[ast_pkg::CTRL_RUN] = state_q == ast_pkg::SCAN_RUN;
            end
            if (wb_adr_i == ast_pkg::ADR_DIV) begin
                dat_d = div_q;
            end
            if (wb_adr_i == ast_pkg::ADR_CHEN) begin
                dat_d[15:0] = {cur_q, chen_q};
            end
            if (wb_adr_i == ast_pkg::ADR_STAT) begin
                dat_d[ast_pkg::STAT_OVF] = ovf_q;
                dat_d[ast_pkg::STAT_EMPTY] = empty;
                dat_d[ast_pkg::STAT_FULL] = full;
                dat_d[ast_pkg::STAT_NCH_LSB +: 4] = count_en(chen_q);
                dat_d[ast_pkg::STAT_LVL_LSB +: LW] = level;
            end
            if (wb_adr_i == ast_pkg::ADR_FIFO && pop) begin
                dat_d[ast_pkg::ENT_W-1:0] = rdata;
                dat_d[ast_pkg::DAT_VLD] = 1'b1;
            end
            if (wb_adr_i == ast_pkg::ADR_DIRECT) begin
                dat_d[ast_pkg::ENT_W-1:0] = {dch_q, dda_q};
                dat_d[ast_pkg::DAT_VLD] = fresh_q;
                fresh_d = 1'b0;
            end
            for (int c = 0; c < 8; c++) begin
                if (wb_adr_i == ast_pkg::ADR_OFFS + 8'(4 * c)) begin
                    dat_d[15:0] = offs_q[c];
                end
                if (wb_adr_i == ast_pkg::ADR_GAIN + 8'(4 * c)) begin
                    dat_d[15:0] = gain_q[c];
                end
            end
        end
        if (ovf_set) begin
            ovf_d = 1'b1;
        end
        if (cor_if.valid && single_q) begin
            fresh_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            single_q <= 1'b0;
            div_q <= ast_pkg::DIV_RST;
            chen_q <= ast_pkg::CHEN_RST;
            cur_q <= ast_pkg::CUR_RST;
            offs_q <= '{default: ast_pkg::OFFS_RST};
            gain_q <= '{default: ast_pkg::GAIN_RST};
            ovf_q <= 1'b0;
            fresh_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            single_q <= single_d;
            div_q <= div_d;
            chen_q <= chen_d;
            cur_q <= cur_d;
            offs_q <= offs_d;
            gain_q <= gain_d;
            ovf_q <= ovf_d;
            fresh_q <= fresh_d;
        end
    end

    // ============================================================
    // time base and converter tick
    assign div_eff = (div_q < ast_pkg::DIV_MIN) ? ast_pkg::DIV_MIN : div_q;
    assign tb_sum = tb_acc_q + 9'(ast_pkg::TB_MHZ);
    assign tb_en = tb_sum >= 9'(ast_pkg::CLK_MHZ);

    // fractional 40 MHz enable, then integer division
    always_comb begin
        tb_acc_d = tb_en ? tb_sum - 9'(ast_pkg::CLK_MHZ) : tb_sum;
        div_cnt_d = div_cnt_q;
        tick_d = 1'b0;
        if (tb_en) begin
            if (div_cnt_q >= div_eff - 32'h0000_0001) begin
                div_cnt_d = 32'h0000_0000;
                tick_d = 1'b1;
            end else begin
                div_cnt_d = div_cnt_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tb_acc_q <= 9'h000;
            div_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            tb_acc_q <= tb_acc_d;
            div_cnt_q <= div_cnt_d;
            tick_q <= tick_d;
        end
    end

    // ============================================================
    // channel scan sequencer
    assign nxt = next_chan(chan_q, chen_q);

    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        start_d = 1'b0;
        unique case (state_q)
            ast_pkg::SCAN_IDLE: begin
                if (run_set) begin
                    state_d = ast_pkg::SCAN_RUN;
                    chan_d = 3'h7;
                end
            end
            ast_pkg::SCAN_RUN: begin
                if (run_clr) begin
                    state_d = ast_pkg::SCAN_IDLE;
                end else if (tick_q && chen_q != 8'h00) begin
                    start_d = 1'b1;
                    chan_d = nxt;
                    if (single_q && next_chan(nxt, chen_q) <= nxt) begin
                        state_d = ast_pkg::SCAN_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ast_pkg::SCAN_IDLE;
            chan_q <= 3'h7;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            start_q <= start_d;
        end
    end

    assign conv_start_o = start_q;
    assign conv_chan_o = chan_q;

    // ============================================================
    // converter result capture and correction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
        end else begin
            done_s1 <= conv_done_i;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
            data_s1 <= conv_data_i;
            data_s2 <= data_s1;
        end
    end

    assign raw_if.valid = done_s2 && !done_s3;
    assign raw_if.chan = chan_q;
    assign raw_if.data = data_s2;

    ast_corr u_corr (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .gain_i (gain_q[chan_q]),
        .offs_i (offs_q[chan_q]),
        .cur_i (cur_q[chan_q]),
        .raw (raw_if),
        .cor (cor_if)
    );

    // ============================================================
    // sample fifo and direct path
    assign level = wr_q - rd_q;
    assign full = level == LW'(FIFO_DEPTH);
    assign empty = level == '0;
    assign push_req = cor_if.valid && !single_q;
    assign push = push_req && !full;
    assign ovf_set = push_req && full;

    always_comb begin
        wr_d = push ? wr_q + LW'(1) : wr_q;
        rd_d = pop ? rd_q + LW'(1) : rd_q;
        dv_d = cor_if.valid && single_q;
        dch_d = dv_d ? cor_if.chan : dch_q;
        dda_d = dv_d ? cor_if.data : dda_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            wr_vis_q <= '0;
            dv_q <= 1'b0;
            dch_q <= 3'h0;
            dda_q <= 16'h0000;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            wr_vis_q <= wr_q;
            dv_q <= dv_d;
            dch_q <= dch_d;
            dda_q <= dda_d;
        end
    end

    ast_mem #(.W(ast_pkg::ENT_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_mem (
        .clk_i (clk_i),
        .we_i (push),
        .waddr_i (wr_q[FIFO_AW-1:0]),
        .wdata_i ({cor_if.chan, cor_if.data}),
        .raddr_i (rd_q[FIFO_AW-1:0]),
        .rdata_o (rdata)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign direct_valid_o = dv_q;
    assign direct_chan_o = dch_q;
    assign direct_data_o = dda_q;

    // ============================================================
    // checks
    logic [15:0] since_q;
    logic seen_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_q <= 16'h0000;
            seen_q <= 1'b0;
        end else begin
            since_q <= tick_q ? 16'h0000 : (since_q == 16'hFFFF ? since_q : since_q + 16'h0001);
            seen_q <= seen_q || tick_q;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_tick_gap: assert property (tick_q && seen_q |-> since_q >= 16'(ast_pkg::MIN_GAP - 1))
        else $error("converter ticks closer than the rate limit");
    a_start_tick: assert property (conv_start_o |-> $past(tick_q))
        else $error("conversion started without a tick");
    a_chan_enabled: assert property (conv_start_o |-> chen_q[conv_chan_o])
        else $error("disabled channel converted");
    a_trig_start: assert property ($rose(state_q == ast_pkg::SCAN_RUN) |-> $past(run_set))
        else $error("acquisition began without a trigger write");
    // no enabled channel may be skipped between the last start and this one
    a_scan_order: assert property (start_d |-> chen_q[chan_d] && ((chan_d > chan_q) ?
        ((chen_q & (8'hFF << (4'(chan_q) + 4'h1)) & ~(8'hFF << chan_d)) == 8'h00) :
        ((chen_q & ((8'hFF << (4'(chan_q) + 4'h1)) | ~(8'hFF << chan_d))) == 8'h00)))
        else $error("scan order broken");
    a_full_hold: assert property (full && !pop |=> wr_q == $past(wr_q))
        else $error("write into full fifo");
    a_ovf_set: assert property (cor_if.valid && !single_q && full |=> ovf_q)
        else $error("overflow not flagged");
    a_level_max: assert property (level <= LW'(FIFO_DEPTH))
        else $error("fifo level beyond depth");
    a_direct_mode: assert property (cor_if.valid |=> direct_valid_o == $past(single_q))
        else $error("result sent on the wrong path");
endmodule : ast_scan_timing
`default_nettype wire

// ===== shared/ast_pkg.sv
// ============================================================
// scan timing constants
package ast_pkg;
    // channels and sample format
    localparam int NCH = 8;
    localparam int CH_W = 3;
    localparam int SMP_W = 16;
    localparam int ENT_W = SMP_W + CH_W;
    // time base and converter limit
    localparam int CLK_MHZ = 250;
    localparam int TB_MHZ = 40;
    localparam int ADC_MAX_KSPS = 200;
    localparam int DIV_MIN_I = TB_MHZ * 1000 / ADC_MAX_KSPS;
    localparam logic [31:0] DIV_MIN = 32'(DIV_MIN_I);
    localparam logic [31:0] DIV_RST = 32'h0000_00C8;
    // fewest clk cycles between two converter ticks
    localparam int MIN_GAP = (DIV_MIN_I * CLK_MHZ + TB_MHZ - 1) / TB_MHZ;
    // sample fifo
    localparam int FIFO_DEPTH = 4096;
    localparam int FIFO_AW = 12;
    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DIV = 8'h04;
    localparam logic [7:0] ADR_CHEN = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;
    localparam logic [7:0] ADR_FIFO = 8'h10;
    localparam logic [7:0] ADR_DIRECT = 8'h14;
    localparam logic [7:0] ADR_OFFS = 8'h20;
    localparam logic [7:0] ADR_GAIN = 8'h40;
    // field positions
    localparam int CTRL_TRIG = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_SINGLE = 2;
    localparam int CTRL_RUN = 3;
    localparam int CHEN_CUR_LSB = 8;
    localparam int STAT_OVF = 0;
    localparam int STAT_EMPTY = 1;
    localparam int STAT_FULL = 2;
    localparam int STAT_NCH_LSB = 8;
    localparam int STAT_LVL_LSB = 16;
    localparam int DAT_CH_LSB = 16;
    localparam int DAT_VLD = 31;
    // reset values and correction scale
    localparam logic [7:0] CHEN_RST = 8'h01;
    localparam logic [7:0] CUR_RST = 8'h00;
    localparam logic [15:0] OFFS_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam int GAIN_SHIFT = 15;
    localparam logic [15:0] SMP_MAX = 16'hFFFF;
    // scan sequencer
    typedef enum logic {SCAN_IDLE, SCAN_RUN} ast_scan_t;
endpackage : ast_pkg

// ===== shared/ast_smp_if.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// one tagged sample between pipeline stages
interface ast_smp_if;
    logic valid;
    logic [ast_pkg::CH_W-1:0] chan;
    logic [ast_pkg::SMP_W-1:0] data;
    modport src (output valid, output chan, output data);
    modport dst (input valid, input chan, input data);
endinterface : ast_smp_if
`default_nettype wire

// ===== tb/ast_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// converter model: slower answer on higher channels
module ast_conv_model (
    // clock
    input wire logic clk_i,
    // converter control
    input wire logic start_i,
    input wire logic [2:0] chan_i,
    // converter result
    output logic done_o,
    output logic [15:0] data_o
);
    int cnt = 0;
    initial done_o = 1'b0;
    initial data_o = 16'h0000;
    // result carries its channel; data scrambled while converting
    always @(posedge clk_i) begin
        if (start_i) begin
            done_o <= 1'b0;
            data_o <= ~data_o;
            cnt <= 3 + 4 * int'(chan_i);
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                done_o <= 1'b1;
                data_o <= {chan_i, 13'h00A5};
            end
        end
    end
endmodule : ast_conv_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, done, start;
    logic direct_valid;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic [15:0] cdat;
    logic [2:0] cchan, dchan;
    logic [15:0] ddat;
    int bad_count = 0, checked = 0, cyc_n = 0, gap = 0, seen = 0, dv_n = 0;
    always #2 clk_i = ~clk_i;
    // shallow fifo so that full and overflow are reachable in a short run
    ast_scan_timing #(.FIFO_DEPTH(4), .FIFO_AW(2)) i_ast_scan_timing (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .conv_done_i(done), .conv_data_i(cdat),
        .conv_start_o(start), .conv_chan_o(cchan), .direct_valid_o(direct_valid),
        .direct_chan_o(dchan), .direct_data_o(ddat));
    ast_conv_model i_ast_conv_model (.clk_i(clk_i), .start_i(start), .chan_i(cchan),
        .done_o(done), .data_o(cdat));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one classic cycle, waits for ack, then a gap cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    // spacing of converter starts, even with a divisor below the floor
    always @(posedge clk_i) begin
        gap <= start ? 0 : gap + 1;
        if (start === 1'b1 && seen > 0) chk({31'h0, gap + 1 >= ast_pkg::MIN_GAP}, 32'h1);
        if (start === 1'b1) seen <= seen + 1;
        if (direct_valid === 1'b1) dv_n <= dv_n + 1;
        if (++cyc_n == 30000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic test_reset;
        bus(0, 8'h04, 0); chk(q, 32'h0000_00C8);
        bus(0, 8'h08, 0); chk(q, 32'h0000_0001);
        bus(0, 8'h40, 0); chk(q, 32'h0000_8000);
        bus(0, 8'h18, 0); chk(q, 32'h0000_0000);
        chk({31'h0, start}, 32'h0);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_scan;
        logic [31:0] exp [4] = '{32'h8001_0000, 32'h8002_40B4, 32'h8004_FFFF, 32'h8001_0000};
        bus(1, 8'h04, 32'h5); bus(0, 8'h04, 0); chk(q, 32'h5);
        bus(1, 8'h24, 32'h8000); bus(1, 8'h28, 32'h10); bus(1, 8'h50, 32'hFFFF);
        bus(1, 8'h08, 32'h0416); bus(1, 8'h00, 32'h1);
        q = 0;
        for (int i = 0; i < 8000 && q[28:16] < 13'd4; i++) bus(0, 8'h0C, 0);
        bus(1, 8'h00, 32'h2);
        for (int i = 0; i < 4; i++) begin
            bus(0, 8'h10, 0); chk(q, exp[i]);
        end
        $display("test_scan done");
    endtask : test_scan
    task automatic test_single;
        bus(1, 8'h08, 32'h80); bus(1, 8'h3C, 32'h7FFF); bus(1, 8'h00, 32'h5);
        q = 0;
        for (int i = 0; i < 3000 && q[31] !== 1'b1; i++) bus(0, 8'h14, 0);
        chk(q, 32'h8007_FFFF);
        chk({13'h0, dchan, ddat}, 32'h0007_FFFF);
        chk(dv_n, 32'h1);
        bus(0, 8'h0C, 0); chk({19'h0, q[28:16]}, 32'h0);
        $display("test_single done");
    endtask : test_single
    // fill the fifo, let one more sample overflow, clear the flag, drain
    task automatic test_ovf;
        bus(1, 8'h08, 32'h1); bus(1, 8'h00, 32'h1);
        bus(0, 8'h00, 0); chk(q, 32'h8);
        q = 0;
        for (int i = 0; i < 3000 && q[0] !== 1'b1; i++) bus(0, 8'h0C, 0);
        chk(q, 32'h0004_0105);
        bus(1, 8'h00, 32'h2); bus(1, 8'h0C, 32'h1); bus(0, 8'h0C, 0);
        chk(q, 32'h0004_0104);
        for (int i = 0; i < 4; i++) begin
            bus(0, 8'h10, 0); chk(q, 32'h8000_00A5);
        end
        bus(0, 8'h10, 0); chk(q, 32'h0);
        $display("test_ovf done");
    endtask : test_ovf
    task automatic give_verdict;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_scan();
        test_single();
        test_ovf();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
